// ### design/sfs_fifo.sv
// small parameterised fifo with registered outputs
`timescale 1ns/1ps
module sfs_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
	// ----------------------------------------------------------------
	// storage and pointers
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] mem_r [DEPTH]; // word slots
	logic [PW-1:0] wr_ptr_r; // next slot to fill
	logic [PW-1:0] rd_ptr_r; // slot shown at output
	logic [CW-1:0] cnt_r; // words held
	wire push = in_valid & in_ready; // accepted write
	wire pop = out_valid & out_ready; // accepted read
	wire [PW-1:0] wr_ptr_nxt = (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
	wire [PW-1:0] rd_ptr_nxt = !pop ? rd_ptr_r : (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
	wire [CW-1:0] cnt_nxt = cnt_r + CW'(push) - CW'(pop);
	// a word written into the slot about to be shown bypasses the array
	wire [WIDTH-1:0] head_nxt = (push && wr_ptr_r == rd_ptr_nxt) ? in_data : mem_r[rd_ptr_nxt];
	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// ready and valid are registered so the ports come from flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wr_ptr_r <= push ? wr_ptr_nxt : wr_ptr_r;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != FULL_CNT);
			out_valid <= (cnt_nxt != '0);
			out_data <= head_nxt;
		end
	end
	// data slots carry no reset
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end
endmodule : sfs_fifo

// ### design/sfs_seq.sv
// erase and page program command sequencer for a serial nor flash
`timescale 1ns/1ps
module sfs_seq import sfs_pkg::*; (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] io_lines,
	input wire logic [4:0] block_protect_bits,
	input wire logic quad_enable_bit,
	input wire logic arr_done,
	input wire logic arr_ld_ready,
	output logic arr_ld_valid,
	output logic [LOAD_W-1:0] arr_ld_data,
	output logic load_ready,
	output logic arr_start_r,
	output logic arr_abort_r,
	output sfs_op_type arr_op_r,
	output logic [ADDR_W-1:0] arr_addr_r,
	output logic write_enable_latch,
	output logic write_in_progress,
	output logic cmd_reject_r
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic sclk_s1, sclk_s2, sclk_s3; // serial clock stages
	logic cs_s1, cs_s2, cs_s3; // chip select stages
	logic [3:0] io_s1, io_s2; // data line stages
	// third stages only feed the edge detectors
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{cs_s1, cs_s2, cs_s3} <= 3'h7;
			io_s1 <= 4'h0;
			io_s2 <= 4'h0;
		end else begin
			{sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
			{cs_s1, cs_s2, cs_s3} <= {cs_n, cs_s1, cs_s2};
			io_s1 <= io_lines;
			io_s2 <= io_s1;
		end
	end
	wire sclk_rise = sclk_s2 & ~sclk_s3; // sample point
	wire cs_rise = cs_s2 & ~cs_s3; // deselect
	wire cs_fall = ~cs_s2 & cs_s3; // select
	wire cs_low = ~cs_s2; // frame active
	// ----------------------------------------------------------------
	// sequencer registers
	// ----------------------------------------------------------------
	sfs_state_type state_r, state_nxt; // sequencer state
	sfs_op_type kind_r, kind_nxt; // operation being collected
	logic [7:0] shift_r, shift_nxt; // byte being shifted in
	logic [3:0] bits_r, bits_nxt; // bits of current byte
	logic [3:0] lanes_r, lanes_nxt; // bits taken per clock
	logic [1:0] abytes_r, abytes_nxt; // address bytes taken
	logic [ADDR_W-1:0] addr_r, addr_nxt; // collected address
	logic [7:0] offset_r, offset_nxt; // page offset of next byte
	logic got_data_r, got_data_nxt; // at least one byte loaded
	logic bad_r, bad_nxt; // frame already spoilt
	logic go_r, go_nxt; // launch (1) or abort (0)
	logic latch_nxt, busy_nxt; // status next values
	logic start_nxt, abort_nxt, reject_nxt; // one-cycle outputs
	logic push_r, push_nxt; // load word toward fifo
	logic [LOAD_W-1:0] push_data_r, push_data_nxt; // load word contents
	logic fifo_in_ready; // fifo room, registered there
	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	// msb first on every lane width
	wire [7:0] shift_1 = {shift_r[6:0], io_s2[0]};
	wire [7:0] shift_2 = {shift_r[5:0], io_s2[1:0]};
	wire [7:0] shift_4 = {shift_r[3:0], io_s2[3:0]};
	wire [7:0] shift_in = (lanes_r == LANE_4) ? shift_4 : (lanes_r == LANE_2) ? shift_2 : shift_1;
	wire [3:0] bits_sum = bits_r + lanes_r;
	wire byte_done = (bits_sum == BYTE_BITS);
	wire is_write_en = (shift_in == OPC_WRITE_EN);
	wire is_blk = (shift_in == OPC_BLK64);
	wire is_chip = (shift_in == OPC_CHIP_A) || (shift_in == OPC_CHIP_B);
	wire is_p1 = (shift_in == OPC_PROG_1);
	wire is_p2 = (shift_in == OPC_PROG_2);
	wire is_p4 = (shift_in == OPC_PROG_4);
	// quad program also needs the quad enable bit
	wire is_prog = is_p1 || is_p2 || (is_p4 && quad_enable_bit); // dual rides this path
	wire [3:0] data_lanes = is_p4 ? LANE_4 : is_p2 ? LANE_2 : LANE_1;
	// protection: top 2^(level-1) blocks guarded; upper two bits unused here
	wire [2:0] bp_lvl = block_protect_bits[2:0];
	wire [8:0] prot_span = (bp_lvl == 3'h0) ? 9'h000 : (9'h001 << (bp_lvl - 3'h1));
	wire [9:0] blk_reach = {2'h0, addr_r[23:16]} + {1'b0, prot_span};
	wire region_prot = (prot_span != 9'h000) && (blk_reach >= {1'b0, ARRAY_BLOCKS});
	wire prot_none = (block_protect_bits == BP_NONE);
	// chip erase needs every protect bit off
	wire op_blocked = (kind_r == OP_CHIP) ? !prot_none : region_prot;
	// deselect must land on a byte edge with nothing spoilt
	wire frame_ok = !bad_r && (bits_r == 4'h0) && ((kind_r != OP_PROG) || got_data_r);
	wire fifo_drained = !push_r && !arr_ld_valid;
	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		shift_nxt = shift_r;
		bits_nxt = bits_r;
		lanes_nxt = lanes_r;
		abytes_nxt = abytes_r;
		addr_nxt = addr_r;
		offset_nxt = offset_r;
		got_data_nxt = got_data_r;
		bad_nxt = bad_r;
		go_nxt = go_r;
		latch_nxt = write_enable_latch;
		busy_nxt = write_in_progress;
		start_nxt = 1'b0;
		abort_nxt = 1'b0;
		reject_nxt = 1'b0;
		push_nxt = 1'b0;
		push_data_nxt = push_data_r;
		case (state_r)
			// wait for select; frames during a busy cycle never reach here
			ST_IDLE: begin
				if (cs_fall) begin
					state_nxt = ST_CMD;
					bits_nxt = 4'h0;
					lanes_nxt = LANE_1;
					abytes_nxt = 2'h0;
					got_data_nxt = 1'b0;
					bad_nxt = 1'b0;
				end
			end
			// opcode on line zero
			ST_CMD: begin
				if (cs_rise) begin
					state_nxt = ST_IDLE;
				end else if (sclk_rise) begin
					shift_nxt = shift_in;
					bits_nxt = byte_done ? 4'h0 : bits_sum;
					if (byte_done) begin
						state_nxt = ST_IGNORE;
						if (is_write_en) begin
							latch_nxt = 1'b1;
						end else if (!write_enable_latch) begin
							// latch clear: command dropped
							reject_nxt = is_blk || is_chip || is_prog || is_p4;
						end else if (is_blk) begin
							state_nxt = ST_ADDR;
							kind_nxt = OP_BLOCK;
						end else if (is_chip) begin
							// nothing may follow the opcode
							state_nxt = ST_DATA;
							kind_nxt = OP_CHIP;
						end else if (is_prog) begin
							state_nxt = ST_ADDR;
							kind_nxt = OP_PROG;
							lanes_nxt = data_lanes;
						end else if (is_p4) begin
							// quad enable clear: refused like any bad program
							reject_nxt = 1'b1;
						end
					end
				end
			end
			// three address bytes, high byte first, always on line zero
			ST_ADDR: begin
				if (cs_rise) begin
					state_nxt = ST_IDLE;
					reject_nxt = 1'b1;
				end else if (sclk_rise) begin
					shift_nxt = shift_1;
					bits_nxt = (bits_r + LANE_1 == BYTE_BITS) ? 4'h0 : bits_r + LANE_1;
					if (bits_r + LANE_1 == BYTE_BITS) begin
						addr_nxt = {addr_r[15:0], shift_1};
						abytes_nxt = abytes_r + 2'h1;
						if (abytes_r + 2'h1 == ADDR_BYTES) begin
							state_nxt = ST_DATA;
							offset_nxt = shift_1; // start offset in page
						end
					end
				end
			end
			// data bytes for program; any clock after an erase spoils it
			ST_DATA: begin
				if (cs_rise) begin
					state_nxt = ST_LAUNCH;
					go_nxt = frame_ok && !op_blocked;
					busy_nxt = frame_ok && !op_blocked;
					// protected target: cycle skipped but latch still drops
					latch_nxt = !(frame_ok && op_blocked) && write_enable_latch;
					reject_nxt = !frame_ok || op_blocked;
				end else if (sclk_rise) begin
					if (kind_r != OP_PROG) begin
						bad_nxt = 1'b1;
					end else begin
						shift_nxt = shift_in;
						bits_nxt = byte_done ? 4'h0 : bits_sum;
						if (byte_done) begin
							push_nxt = 1'b1;
							push_data_nxt = {offset_r, shift_in};
							offset_nxt = offset_r + 8'h01; // wraps in page
							got_data_nxt = 1'b1;
							bad_nxt = bad_r || !fifo_in_ready; // overrun spoils frame
						end
					end
				end
			end
			// let the loads drain before commit or discard
			ST_LAUNCH: begin
				if (fifo_drained) begin
					state_nxt = go_r ? ST_BUSY : ST_IDLE;
					start_nxt = go_r;
					abort_nxt = !go_r;
				end
			end
			// self-timed cycle runs in the array
			ST_BUSY: begin
				if (arr_done) begin
					state_nxt = ST_IDLE;
					busy_nxt = 1'b0;
					latch_nxt = 1'b0;
				end
			end
			// rest of an unused or refused frame
			ST_IGNORE: begin
				if (cs_rise) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end
	// ----------------------------------------------------------------
	// state and output registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			kind_r <= OP_BLOCK;
			shift_r <= 8'h00;
			bits_r <= 4'h0;
			lanes_r <= LANE_1;
			abytes_r <= 2'h0;
			addr_r <= '0;
			offset_r <= 8'h00;
			got_data_r <= 1'b0;
			bad_r <= 1'b0;
			go_r <= 1'b0;
			write_enable_latch <= 1'b0;
			write_in_progress <= 1'b0;
			arr_start_r <= 1'b0;
			arr_abort_r <= 1'b0;
			cmd_reject_r <= 1'b0;
			push_r <= 1'b0;
			push_data_r <= '0;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			shift_r <= shift_nxt;
			bits_r <= bits_nxt;
			lanes_r <= lanes_nxt;
			abytes_r <= abytes_nxt;
			addr_r <= addr_nxt;
			offset_r <= offset_nxt;
			got_data_r <= got_data_nxt;
			bad_r <= bad_nxt;
			go_r <= go_nxt;
			write_enable_latch <= latch_nxt;
			write_in_progress <= busy_nxt;
			arr_start_r <= start_nxt;
			arr_abort_r <= abort_nxt;
			cmd_reject_r <= reject_nxt;
			push_r <= push_nxt;
			push_data_r <= push_data_nxt;
		end
	end
	// operation and address held for the array, any block address valid
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			arr_op_r <= OP_BLOCK;
			arr_addr_r <= '0;
		end else if (start_nxt) begin
			arr_op_r <= kind_r;
			arr_addr_r <= addr_r;
		end
	end
	assign load_ready = fifo_in_ready;
	// ----------------------------------------------------------------
	// load fifo toward the page staging buffer
	// ----------------------------------------------------------------
	// later bytes to the same offset overwrite earlier ones
	sfs_fifo #(.WIDTH(LOAD_W), .DEPTH(LOAD_DEPTH)) u_load (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.in_valid(push_r),
		.in_ready(fifo_in_ready),
		.in_data(push_data_r),
		.out_valid(arr_ld_valid),
		.out_ready(arr_ld_ready),
		.out_data(arr_ld_data)
	);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_finish;
		state_r == ST_BUSY && arr_done;
	endsequence
	sequence s_deselect_data;
		cs_rise && state_r == ST_DATA;
	endsequence
	chk_start_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
		arr_start_r |-> write_enable_latch && write_in_progress)
		else $error("array start without latch");
	chk_wip_launch: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_deselect_data ##0 (frame_ok && !op_blocked) |=> write_in_progress && go_r)
		else $error("busy flag not raised at deselect");
	chk_cycle_end: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_finish |=> !write_in_progress && !write_enable_latch && state_r == ST_IDLE)
		else $error("cycle end did not clear flags");
	chk_byte_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_deselect_data ##0 (bits_r != 4'h0) |=> !write_in_progress ##1 !arr_start_r)
		else $error("off-boundary frame launched");
	chk_chip_prot: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_deselect_data ##0 (kind_r == OP_CHIP && !prot_none) |=> !go_r && !write_in_progress)
		else $error("chip erase under protection");
	chk_region_prot: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_deselect_data ##0 (kind_r != OP_CHIP && region_prot) |=> !go_r)
		else $error("protected region launched");
	chk_quad_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_r == ST_CMD && sclk_rise && byte_done && is_p4 && !quad_enable_bit
		|=> state_r != ST_ADDR)
		else $error("quad program without quad enable");
	chk_rise_sample: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(addr_r) |-> $past(sclk_rise))
		else $error("address moved off a clock rise");
	chk_page_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
		state_r == ST_DATA && kind_r == OP_PROG && !cs_rise && sclk_rise && byte_done
		&& offset_r == PAGE_LAST |=> offset_r == 8'h00)
		else $error("page offset did not wrap to zero");
	chk_empty_prog: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_deselect_data ##0 (kind_r == OP_PROG && !got_data_r) |=> !go_r)
		else $error("program without data launched");
endmodule : sfs_seq

// ### inc/sfs_pkg.sv
// shared constants and types for the flash erase/program sequencer
package sfs_pkg;
	// ----------------------------------------------------------------
	// command opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_WRITE_EN = 8'h06; // write_enable_cmd
	localparam logic [7:0] OPC_BLK64 = 8'hD8; // erase_64k_block_cmd
	localparam logic [7:0] OPC_CHIP_A = 8'h60; // chip erase, first code
	localparam logic [7:0] OPC_CHIP_B = 8'hC7; // chip erase, second code
	localparam logic [7:0] OPC_PROG_1 = 8'h02; // program_page_single_cmd
	localparam logic [7:0] OPC_PROG_2 = 8'hA2; // program_page_dual_cmd
	localparam logic [7:0] OPC_PROG_4 = 8'h32; // program_page_quad_cmd
	// ----------------------------------------------------------------
	// widths, counts and array geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24; // flash byte address
	localparam int LOAD_W = 16; // {page offset, data byte}
	localparam int LOAD_DEPTH = 4; // words in the load fifo
	localparam logic [3:0] BYTE_BITS = 4'h8; // bits per byte
	localparam logic [3:0] LANE_1 = 4'h1; // bits per clock, single
	localparam logic [3:0] LANE_2 = 4'h2; // bits per clock, dual
	localparam logic [3:0] LANE_4 = 4'h4; // bits per clock, quad
	localparam logic [1:0] ADDR_BYTES = 2'h3; // address length
	localparam logic [8:0] ARRAY_BLOCKS = 9'h020; // 64K blocks in array
	localparam logic [7:0] PAGE_LAST = 8'hFF; // last offset in a page
	localparam logic [4:0] BP_NONE = 5'h00; // no-protection setting
	// ----------------------------------------------------------------
	// array operations and sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_BLOCK = 2'h0, // erase one 64K block
		OP_CHIP = 2'h1, // erase whole array
		OP_PROG = 2'h2 // program staged page
	} sfs_op_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CMD = 3'h1,
		ST_ADDR = 3'h3,
		ST_DATA = 3'h2,
		ST_LAUNCH = 3'h6,
		ST_BUSY = 3'h7,
		ST_IGNORE = 3'h4
	} sfs_state_type;
endpackage : sfs_pkg

// ### sim/sfs_host_model.sv
// behavioural host spi controller that drives the flash serial pins
`timescale 1ns/1ps
module sfs_host_model import sfs_pkg::*; (
	input wire logic clk_sys,
	output logic sclk,
	output logic cs_n,
	output logic [3:0] io_lines
);
	// ----------------------------------------------------------------
	// pin state and timing
	// ----------------------------------------------------------------
	initial begin
		sclk = 1'b0; // idle low, stands still between frames
		cs_n = 1'b1; // deselected
		io_lines = 4'hA; // no pull on the lines, so no stable idle value
	end
	// half a serial period: 8 system clocks give a 160 ns link clock
	task half();
		repeat (8) @(negedge clk_sys);
	endtask : half
	// one serial clock, data already set up half a period before the rise
	task pulse();
		half();
		sclk = 1'b1;
		half();
		sclk = 1'b0;
	endtask : pulse
	// ----------------------------------------------------------------
	// byte and frame transfers
	// ----------------------------------------------------------------
	// a byte msb first on 1, 2 or 4 lanes; unused lanes toggle as junk
	task send_byte(input logic [7:0] b, input int lanes);
		logic [7:0] sh;
		sh = b;
		for (int k = 0; k < 8 / lanes; k++) begin
			case (lanes)
				1: io_lines = {~io_lines[3:1], sh[7]};
				2: io_lines = {~io_lines[3:2], sh[7:6]};
				default: io_lines = sh[7:4];
			endcase
			sh = sh << lanes;
			pulse();
		end
	endtask : send_byte
	// whole frame: opcode, nab address bytes, nb data bytes, xb stray clocks
	task frame(input logic [7:0] opc, input logic [23:0] addr, input int nab, input int nb,
		input int xb, input logic [7:0] seed);
		int lanes;
		lanes = (opc == OPC_PROG_2) ? 2 : ((opc == OPC_PROG_4) ? 4 : 1);
		cs_n = 1'b0;
		half();
		send_byte(opc, 1);
		for (int i = 0; i < nab; i++) begin
			send_byte(addr[23 - 8 * i -: 8], 1);
		end
		for (int i = 0; i < nb; i++) begin
			send_byte(seed ^ i[7:0], lanes);
		end
		for (int i = 0; i < xb; i++) begin
			pulse(); // stray clocks only when a test asks for them
		end
		half();
		cs_n = 1'b1;
		io_lines = ~io_lines; // released lines lose their last value
		half();
	endtask : frame
endmodule : sfs_host_model

// ### sim/sfs_seq_tb.sv
// self-checking testbench for the flash erase and program sequencer
`timescale 1ns/1ps
module sfs_seq_tb;
	import sfs_pkg::*;
	// ----------------------------------------------------------------
	// signals, counters and case table
	// ----------------------------------------------------------------
	typedef struct {
		logic [7:0] opc;
		logic [23:0] addr;
		int nab;
		int nb;
		int xb;
		logic write_enable_cmd;
		logic [4:0] bp;
		logic qe;
		logic ok;
	} sfs_row_type;
	localparam int LIMIT = 60000; // about four times the expected run
	localparam logic [7:0] SEED = 8'h5A; // data byte i is SEED xor i
	logic clk_sys = 1'b0;
	logic rstn, sclk, cs_n, quad_enable_bit, arr_done, arr_ld_ready;
	logic [3:0] io_lines;
	logic [4:0] block_protect_bits;
	logic arr_ld_valid, load_ready, arr_start_r, arr_abort_r;
	logic write_enable_latch, write_in_progress, cmd_reject_r, lr_low;
	logic [LOAD_W-1:0] arr_ld_data;
	sfs_op_type arr_op_r, st_op;
	logic [ADDR_W-1:0] arr_addr_r, st_addr;
	logic [LOAD_W-1:0] words[$]; // load words seen on the drain side
	int n_errors = 0, checks = 0, cyc = 0, n_start = 0, n_rej = 0, n_abt = 0, s0, j0;
	sfs_row_type rows[17] = '{
		'{OPC_BLK64, 24'h03ABCD, 3, 0, 0, 1'b1, 5'h00, 1'b0, 1'b1},
		'{OPC_CHIP_A, 24'h0, 0, 0, 0, 1'b1, 5'h00, 1'b0, 1'b1},
		'{OPC_CHIP_B, 24'h0, 0, 0, 0, 1'b1, 5'h00, 1'b0, 1'b1},
		'{OPC_BLK64, 24'h03ABCD, 3, 0, 0, 1'b0, 5'h00, 1'b0, 1'b0},
		'{OPC_PROG_1, 24'h0012FE, 3, 3, 0, 1'b1, 5'h00, 1'b0, 1'b1},
		'{OPC_PROG_2, 24'h000410, 3, 3, 0, 1'b1, 5'h00, 1'b0, 1'b1},
		'{OPC_PROG_4, 24'h000520, 3, 2, 0, 1'b1, 5'h00, 1'b1, 1'b1},
		'{OPC_PROG_4, 24'h000520, 3, 2, 0, 1'b1, 5'h00, 1'b0, 1'b0},
		'{OPC_BLK64, 24'h1F0000, 3, 0, 0, 1'b1, 5'h01, 1'b0, 1'b0},
		'{OPC_BLK64, 24'h000000, 3, 0, 0, 1'b1, 5'h01, 1'b0, 1'b1},
		'{OPC_CHIP_A, 24'h0, 0, 0, 0, 1'b1, 5'h08, 1'b0, 1'b0},
		'{OPC_PROG_1, 24'h1F1200, 3, 1, 0, 1'b1, 5'h01, 1'b0, 1'b0},
		'{OPC_BLK64, 24'h03ABCD, 3, 0, 3, 1'b1, 5'h00, 1'b0, 1'b0},
		'{OPC_CHIP_B, 24'h0, 0, 0, 1, 1'b1, 5'h00, 1'b0, 1'b0},
		'{OPC_PROG_1, 24'h000300, 3, 0, 0, 1'b1, 5'h00, 1'b0, 1'b0},
		'{OPC_PROG_1, 24'h000300, 3, 1, 4, 1'b1, 5'h00, 1'b0, 1'b0},
		'{OPC_BLK64, 24'h03ABCD, 2, 0, 0, 1'b1, 5'h00, 1'b0, 1'b0}
	};
	always #5 clk_sys = ~clk_sys; // 100 MHz system clock
	sfs_host_model i_sfs_host_model (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
		.io_lines(io_lines));
	sfs_seq i_sfs_seq (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
		.io_lines(io_lines), .block_protect_bits(block_protect_bits),
		.quad_enable_bit(quad_enable_bit), .arr_done(arr_done), .arr_ld_ready(arr_ld_ready),
		.arr_ld_valid(arr_ld_valid), .arr_ld_data(arr_ld_data), .load_ready(load_ready),
		.arr_start_r(arr_start_r), .arr_abort_r(arr_abort_r), .arr_op_r(arr_op_r),
		.arr_addr_r(arr_addr_r), .write_enable_latch(write_enable_latch),
		.write_in_progress(write_in_progress), .cmd_reject_r(cmd_reject_r));
	// ----------------------------------------------------------------
	// monitor: pulses, load words and the hang limit
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		cyc++;
		if (arr_start_r === 1'b1) begin
			n_start++;
			st_op = arr_op_r; // op and address qualify the start pulse
			st_addr = arr_addr_r;
		end
		if (cmd_reject_r === 1'b1) begin
			n_rej++;
		end
		if (arr_abort_r === 1'b1) begin
			n_abt++;
		end
		if (load_ready === 1'b0) begin
			lr_low = 1'b1;
		end
		if (arr_ld_valid === 1'b1 && arr_ld_ready === 1'b1) begin
			words.push_back(arr_ld_data);
		end
		if (cyc == LIMIT) begin
			n_errors++;
			end_sim();
		end
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// array reports completion; busy and latch must both drop
	task finish_op();
		check("busy", write_in_progress, 1'b1);
		arr_done = 1'b1;
		@(negedge clk_sys);
		arr_done = 1'b0;
		repeat (2) @(negedge clk_sys);
		check("busy end", {write_in_progress, write_enable_latch}, 2'b00);
	endtask : finish_op
	task run_row(input sfs_row_type r);
		int w;
		logic [23:0] m;
		s0 = n_start;
		j0 = n_rej;
		block_protect_bits = r.bp;
		quad_enable_bit = r.qe;
		words.delete();
		if (r.write_enable_cmd) begin
			i_sfs_host_model.frame(OPC_WRITE_EN, 24'h0, 0, 0, 0, SEED);
			check("latch", write_enable_latch, 1'b1);
		end
		i_sfs_host_model.frame(r.opc, r.addr, r.nab, r.nb, r.xb, SEED);
		w = 0;
		while (n_start == s0 && n_rej == j0 && w < 400) begin
			@(negedge clk_sys);
			w++;
		end
		repeat (4) @(negedge clk_sys);
		check("started", 24'(n_start - s0), 24'(r.ok));
		check("refused", 24'(n_rej - j0), 24'(!r.ok));
		if (r.ok) begin
			m = (r.opc == OPC_BLK64) ? 24'hFF0000 : ((r.nb > 0) ? 24'hFFFF00 : 24'h0);
			check("op", 24'(st_op), (r.opc == OPC_BLK64) ? 24'(OP_BLOCK) :
				((r.nb > 0) ? 24'(OP_PROG) : 24'(OP_CHIP)));
			check("addr", st_addr & m, r.addr & m);
			check("words", 24'(words.size()), 24'(r.nb));
			for (int k = 0; k < r.nb; k++) begin
				check("word", 24'(words[k]), {8'h00, r.addr[7:0] + k[7:0], SEED ^ k[7:0]});
			end
			finish_op();
		end
	endtask : run_row
	task end_sim();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	// ----------------------------------------------------------------
	// main sequence: reset, table, then awkward cases
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		block_protect_bits = 5'h00;
		quad_enable_bit = 1'b0;
		arr_done = 1'b0;
		arr_ld_ready = 1'b1;
		repeat (16) @(negedge clk_sys);
		check("reset outs", {arr_ld_valid, arr_start_r, arr_abort_r, arr_op_r, write_enable_latch,
			write_in_progress, cmd_reject_r, load_ready}, 24'h001);
		rstn = 1'b1;
		repeat (4) @(negedge clk_sys);
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		// drain side stalls: fifo fills, frame is spoiled, staged words dropped
		arr_ld_ready = 1'b0;
		lr_low = 1'b0;
		run_row('{OPC_PROG_4, 24'h000700, 3, 8, 0, 1'b1, 5'h00, 1'b1, 1'b0});
		check("fifo full", lr_low, 1'b1);
		s0 = n_abt;
		arr_ld_ready = 1'b1;
		repeat (30) @(negedge clk_sys);
		check("abort", 24'(n_abt - s0), 24'h1);
		// start a real erase and leave it running; frames sent while busy are ignored
		s0 = n_start;
		i_sfs_host_model.frame(OPC_WRITE_EN, 24'h0, 0, 0, 0, SEED);
		i_sfs_host_model.frame(OPC_BLK64, 24'h020000, 3, 0, 0, SEED);
		repeat (10) @(negedge clk_sys);
		check("busy start", 24'(n_start - s0), 24'h1);
		s0 = n_start;
		j0 = n_rej;
		i_sfs_host_model.frame(OPC_WRITE_EN, 24'h0, 0, 0, 0, SEED);
		i_sfs_host_model.frame(OPC_BLK64, 24'h030000, 3, 0, 0, SEED);
		i_sfs_host_model.frame(OPC_CHIP_A, 24'h0, 0, 0, 0, SEED);
		repeat (10) @(negedge clk_sys);
		check("ignored", 24'(n_start - s0), 24'h0);
		check("ignored refusals", 24'(n_rej - j0), 24'h0);
		finish_op();
		end_sim();
	end
endmodule : sfs_seq_tb
